// file: include/idwnc_pkg.sv
`default_nettype none
package idwnc_pkg;
  localparam logic [3:0] ADDR_HI = 4'h5;
  localparam logic [3:0] OP_LIVE_WRITE = 4'h1;
  localparam logic [3:0] OP_SAVED_WRITE = 4'h2;
  localparam logic [3:0] OP_RECALL = 4'h6;
  localparam logic [3:0] OP_STORE = 4'h5;
  localparam logic [3:0] TGT_A = 4'h1;
  localparam logic [3:0] TGT_B = 4'h2;
  localparam logic [3:0] TGT_AB = 4'h3;
  localparam logic [7:0] WIPER_MID = 8'h80;
  localparam int WIPERS = 2;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int SYNC_W = 8;
  localparam int INIT_TIME_NS = 10000;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int INIT_CNT_W = 9;
  localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES - 1);
  typedef enum logic {ST_POWERUP, ST_READY} idwnc_state_e;
endpackage
`default_nettype wire

// file: logic/idwnc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module idwnc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // The first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // idwnc_sync
`default_nettype wire

// file: logic/idwnc_link.sv
`timescale 1ns/1ps
`default_nettype none
module idwnc_link (
  input wire logic scl_clk,
  input wire logic link_rst_n,
  input wire logic sda_i,
  input wire logic [6:0] dev_addr,
  output logic sda_oe,
  output logic [7:0] cmd_out,
  output logic [7:0] data_out,
  output logic evt_tgl,
  output logic addressed
);
  logic start_tgl_reg;
  logic start_seen_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic addressed_reg;
  logic write_mode_reg;
  logic [7:0] cmd_reg;
  logic [7:0] data_reg;
  logic evt_reg;
  logic ack_reg;
  logic new_start;
  logic ack_clk;
  logic addr_match;

  // A start is a falling data edge while the clock is high
  always_ff @(negedge sda_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      start_tgl_reg <= 1'b0;
    else if (scl_clk)
      start_tgl_reg <= ~start_tgl_reg;
  end

  assign new_start = start_tgl_reg != start_seen_reg;
  assign ack_clk = bit_cnt_reg == idwnc_pkg::BIT_ACK;
  assign addr_match = shift_reg[7:1] == dev_addr;

  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      start_seen_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= idwnc_pkg::BYTE_ADDR;
    end
    else
    begin
      start_seen_reg <= start_tgl_reg;
      if (new_start)
      begin
        bit_cnt_reg <= idwnc_pkg::BIT_FIRST;
        shift_reg <= {7'h00, sda_i};
        byte_idx_reg <= idwnc_pkg::BYTE_ADDR;
      end
      else if (ack_clk)
      begin
        bit_cnt_reg <= 4'h0;
        if (byte_idx_reg != idwnc_pkg::BYTE_LAST)
          byte_idx_reg <= byte_idx_reg + 2'h1;
      end
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], sda_i};
      end
    end
  end

  // Only the first data byte after the command is acted on
  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      addressed_reg <= 1'b0;
      write_mode_reg <= 1'b0;
      cmd_reg <= 8'h00;
      data_reg <= 8'h00;
      evt_reg <= 1'b0;
    end
    else if (new_start)
    begin
      addressed_reg <= 1'b0;
      write_mode_reg <= 1'b0;
    end
    else if (ack_clk)
    begin
      if (byte_idx_reg == idwnc_pkg::BYTE_ADDR)
      begin
        addressed_reg <= addr_match;
        write_mode_reg <= addr_match & ~shift_reg[0];
      end
      else if (byte_idx_reg == idwnc_pkg::BYTE_CMD && write_mode_reg)
        cmd_reg <= shift_reg;
      else if (byte_idx_reg == idwnc_pkg::BYTE_DATA && write_mode_reg)
      begin
        data_reg <= shift_reg;
        evt_reg <= ~evt_reg;
      end
    end
  end

  // Pull low from the falling edge after bit 8 to the one after the ack clock
  always_ff @(negedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= ack_clk &&
                 (byte_idx_reg == idwnc_pkg::BYTE_ADDR ? addr_match : addressed_reg);
  end

  assign sda_oe = ack_reg;
  assign cmd_out = cmd_reg;
  assign data_out = data_reg;
  assign evt_tgl = evt_reg;
  assign addressed = addressed_reg;

  property p_ack_slot;
    @(posedge scl_clk) disable iff (!link_rst_n)
    sda_oe |-> bit_cnt_reg == 4'h8;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside ninth clock");

  property p_ack_addr;
    @(posedge scl_clk) disable iff (!link_rst_n)
    (sda_oe && byte_idx_reg == 2'h0) |-> shift_reg[7:4] == 4'h5;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack on foreign address");

  property p_noop_quiet;
    @(posedge scl_clk) disable iff (!link_rst_n)
    (ack_clk && !write_mode_reg && !new_start) |=> $stable(evt_reg);
  endproperty
  a_noop_quiet: assert property (p_noop_quiet) else $error("noop access raised a command");
endmodule // idwnc_link
`default_nettype wire

// file: logic/idwnc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each byte is followed by a ninth, master-clocked acknowledge bit.
// - Receiver holds data low through the high phase of the ack clock.
// - Respond only to seven-bit address 0101 followed by the strap bits.
// - Three strap inputs set the low address bits, eight devices per bus.
// - Bit eight low means write, high means no-op changing nothing.
// - First data byte after the command goes to the selected register.
// - Live write loads the live register; the wiper follows it.
// - Saved write loads the saved register; live value and wiper stay.
// - Recall copies saved value into live register and wiper.
// - Store copies live value into the saved register.
// - Sixteen-bit saved store, one byte per wiper, survives power loss.
// - Saved store starts at midscale for both wipers.
// - Write protect high or floating blocks every saved-store write.
// - Under protection a live write loads the saved value, not bus data.
// - Protection low allows saved writes and direct bus updates.
// - After reset both saved values load into live registers within 10 us.
// - Standby whenever the power-up window is over and no transfer addressed to this device is running.
// - Upper nibble picks operation, lower nibble picks wiper A, B or both.
module idwnc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic nv_init_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic wp,
  output logic [7:0] wiper_a,
  output logic [7:0] wiper_b,
  output logic [15:0] nv_word,
  output logic init_busy,
  output logic standby
);
  idwnc_pkg::idwnc_state_e state_reg;
  logic [idwnc_pkg::INIT_CNT_W-1:0] init_cnt_reg;
  logic link_rst_n_reg;
  logic [2:0] strap_reg;
  logic [idwnc_pkg::SYNC_W-1:0] sync_in;
  logic [idwnc_pkg::SYNC_W-1:0] sync_out;
  logic link_evt;
  logic link_addressed;
  logic link_sda_oe;
  logic [7:0] link_cmd;
  logic [7:0] link_data;
  logic evt_s;
  logic addressed_s;
  logic wp_s;
  logic scl_s;
  logic sda_s;
  logic sda_prev_reg;
  logic in_frame_reg;
  logic evt_seen_reg;
  logic do_cmd;
  logic load_init;
  logic [1:0][7:0] live_vec;
  logic [1:0][7:0] saved_vec;

  // Decodes whether a command byte acts on wiper w; unknown codes hit nothing
  function automatic logic cmd_hits(input logic [7:0] cmd, input int w);
    logic op_ok;
    logic tgt_ok;
    op_ok = cmd[7:4] == idwnc_pkg::OP_LIVE_WRITE || cmd[7:4] == idwnc_pkg::OP_SAVED_WRITE ||
            cmd[7:4] == idwnc_pkg::OP_RECALL || cmd[7:4] == idwnc_pkg::OP_STORE;
    tgt_ok = cmd[3:0] == idwnc_pkg::TGT_AB ||
             cmd[3:0] == ((w == 0) ? idwnc_pkg::TGT_A : idwnc_pkg::TGT_B);
    return op_ok && tgt_ok;
  endfunction

  // Link domain held in reset while the core is; scl is idle then
  always_ff @(posedge clk)
  begin
    link_rst_n_reg <= resetn;
  end

  idwnc_link u_link (
    .scl_clk(scl_clk),
    .link_rst_n(link_rst_n_reg),
    .sda_i(sda_i),
    .dev_addr({idwnc_pkg::ADDR_HI, strap_reg}),
    .sda_oe(link_sda_oe),
    .cmd_out(link_cmd),
    .data_out(link_data),
    .evt_tgl(link_evt),
    .addressed(link_addressed)
  );

  assign sync_in = {link_evt, link_addressed, wp, scl_clk, sda_i,
                    addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  idwnc_sync #(
    .W(idwnc_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(sync_in),
    .q(sync_out)
  );

  assign evt_s = sync_out[7];
  assign addressed_s = sync_out[6];
  assign wp_s = sync_out[5];
  assign scl_s = sync_out[4];
  assign sda_s = sync_out[3];

  // Straps follow the synchroniser through the power-up window, then freeze;
  // the synchroniser clears under reset, so its output is not valid at once
  always_ff @(posedge clk)
  begin
    if (!resetn)
      strap_reg <= 3'h0;
    else if (init_busy)
      strap_reg <= sync_out[2:0];
  end

  // Power-up recall window
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= idwnc_pkg::ST_POWERUP;
      init_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        idwnc_pkg::ST_POWERUP:
        begin
          init_cnt_reg <= init_cnt_reg + {{(idwnc_pkg::INIT_CNT_W-1){1'b0}}, 1'b1};
          if (init_cnt_reg == idwnc_pkg::INIT_LAST)
            state_reg <= idwnc_pkg::ST_READY;
        end
        idwnc_pkg::ST_READY:
        begin
          init_cnt_reg <= '0;
        end
      endcase
    end
  end

  assign load_init = state_reg == idwnc_pkg::ST_POWERUP && init_cnt_reg == '0;
  assign init_busy = state_reg == idwnc_pkg::ST_POWERUP;

  // Commands that land during power-up wait in the toggle until ready
  assign do_cmd = state_reg == idwnc_pkg::ST_READY && evt_s != evt_seen_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      evt_seen_reg <= 1'b0;
    else if (do_cmd)
      evt_seen_reg <= evt_s;
  end

  // Bus start and stop as seen from the core clock
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sda_prev_reg <= 1'b1;
      in_frame_reg <= 1'b0;
    end
    else
    begin
      sda_prev_reg <= sda_s;
      if (scl_s && sda_prev_reg && !sda_s)
        in_frame_reg <= 1'b1;
      else if (scl_s && !sda_prev_reg && sda_s)
        in_frame_reg <= 1'b0;
    end
  end

  assign standby = !init_busy && !(in_frame_reg && addressed_s);

  // Link command and data are stable for many bus clocks after the toggle
  generate
    for (genvar w = 0; w < idwnc_pkg::WIPERS; w++)
    begin : g_wiper
      logic [7:0] live_reg;
      logic [7:0] saved_reg;
      logic hit;

      assign hit = do_cmd && cmd_hits(link_cmd, w);

      always_ff @(posedge clk)
      begin
        if (!resetn)
          live_reg <= idwnc_pkg::WIPER_MID;
        else if (load_init)
          live_reg <= saved_reg;
        else if (hit && link_cmd[7:4] == idwnc_pkg::OP_LIVE_WRITE)
          live_reg <= wp_s ? saved_reg : link_data;
        else if (hit && link_cmd[7:4] == idwnc_pkg::OP_RECALL)
          live_reg <= saved_reg;
      end

      // Saved bytes ignore the core reset so they outlive it
      always_ff @(posedge clk)
      begin
        if (!nv_init_n)
          saved_reg <= idwnc_pkg::WIPER_MID;
        else if (hit && !wp_s && link_cmd[7:4] == idwnc_pkg::OP_SAVED_WRITE)
          saved_reg <= link_data;
        else if (hit && !wp_s && link_cmd[7:4] == idwnc_pkg::OP_STORE)
          saved_reg <= live_reg;
      end

      assign live_vec[w] = live_reg;
      assign saved_vec[w] = saved_reg;
    end
  endgenerate

  assign wiper_a = live_vec[0];
  assign wiper_b = live_vec[1];
  assign nv_word = {saved_vec[1], saved_vec[0]};
  assign sda_o = 1'b0;
  assign sda_oe = link_sda_oe;

  // Checks
  localparam int INIT_LEN = 400;
  logic [9:0] busy_len_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      busy_len_reg <= 10'h000;
    else if (init_busy)
      busy_len_reg <= busy_len_reg + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_init_len;
    $fell(init_busy) |-> busy_len_reg == 10'(INIT_LEN);
  endproperty
  a_init_len: assert property (p_init_len) else $error("power-up window wrong length");

  property p_init_recall;
    $fell(init_busy) |-> wiper_a == nv_word[7:0] && wiper_b == nv_word[15:8];
  endproperty
  a_init_recall: assert property (p_init_recall) else $error("wipers not recalled");

  property p_live_write;
    (do_cmd && cmd_hits(link_cmd, 0) && link_cmd[7:4] == 4'h1 && !wp_s)
      |=> wiper_a == $past(link_data);
  endproperty
  a_live_write: assert property (p_live_write) else $error("live write lost");

  property p_protect_live;
    (do_cmd && cmd_hits(link_cmd, 1) && link_cmd[7:4] == 4'h1 && wp_s)
      |=> wiper_b == nv_word[15:8];
  endproperty
  a_protect_live: assert property (p_protect_live) else $error("protected wiper took bus data");

  property p_saved_write;
    (do_cmd && cmd_hits(link_cmd, 0) && link_cmd[7:4] == 4'h2 && !wp_s && nv_init_n)
      |=> nv_word[7:0] == $past(link_data) && $stable(wiper_a);
  endproperty
  a_saved_write: assert property (p_saved_write) else $error("saved write wrong");

  property p_protect_saved;
    (wp_s && nv_init_n) |=> $stable(nv_word);
  endproperty
  a_protect_saved: assert property (p_protect_saved) else $error("saved store written under protect");

  property p_recall;
    (do_cmd && cmd_hits(link_cmd, 1) && link_cmd[7:4] == 4'h6) |=> wiper_b == nv_word[15:8];
  endproperty
  a_recall: assert property (p_recall) else $error("recall failed");

  property p_store;
    (do_cmd && cmd_hits(link_cmd, 0) && link_cmd[7:4] == 4'h5 && !wp_s && nv_init_n)
      |=> nv_word[7:0] == $past(wiper_a);
  endproperty
  a_store: assert property (p_store) else $error("store failed");

  property p_unknown_cmd;
    (do_cmd && !cmd_hits(link_cmd, 0) && !cmd_hits(link_cmd, 1) && nv_init_n)
      |=> $stable(wiper_a) && $stable(wiper_b) && $stable(nv_word);
  endproperty
  a_unknown_cmd: assert property (p_unknown_cmd) else $error("unknown command changed state");

  property p_both;
    (do_cmd && link_cmd == 8'h13 && !wp_s) |=> wiper_a == wiper_b;
  endproperty
  a_both: assert property (p_both) else $error("both-wiper write diverged");

  property p_awake;
    (in_frame_reg && addressed_s) |-> !standby;
  endproperty
  a_awake: assert property (p_awake) else $error("standby during addressed transfer");

  property p_midscale;
    !nv_init_n |=> nv_word == 16'h8080;
  endproperty
  a_midscale: assert property (p_midscale) else $error("saved store not midscale");

  c_live_both: cover property (do_cmd && link_cmd == 8'h13);
  c_store: cover property (do_cmd && link_cmd[7:4] == 4'h5 && !wp_s);
  c_recall: cover property (do_cmd && link_cmd[7:4] == 4'h6);
  c_protect: cover property (do_cmd && link_cmd[7:4] == 4'h2 && wp_s);
endmodule // idwnc_top
`default_nettype wire

// file: verif/idwnc_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model: scl stands high outside frames, sda is released to the pull-up
module idwnc_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  localparam int QTR = 40;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data changes only while scl is low; low_seen needs the line low just after scl rises and again just before it falls
  task automatic put_bit(input logic b, output logic low_seen);
    begin
      sda_low = ~b;
      #QTR;
      scl = 1'b1;
      #1;
      low_seen = ~sda_line;
      #(2*QTR-2);
      low_seen = low_seen & ~sda_line;
      #1;
      scl = 1'b0;
      #QTR;
    end
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic dummy;
    begin
      for (int i = 7; i >= 0; i--)
      begin
        put_bit(b[i], dummy);
      end
      put_bit(1'b1, acked);
    end
  endtask
  // Bytes go out from the top of the word: address with write bit, command, data
  task automatic frame(input logic [31:0] bytes, input int n, output logic [3:0] acks);
    begin
      acks = 4'h0;
      sda_low = 1'b1;
      #QTR;
      scl = 1'b0;
      for (int k = 0; k < n; k++)
      begin
        send_byte(bytes[31-8*k -: 8], acks[k]);
      end
      sda_low = 1'b1;
      #QTR;
      scl = 1'b1;
      #QTR;
      sda_low = 1'b0;
      #(2*QTR);
    end
  endtask
endmodule // idwnc_master
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic wp;
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [15:0] env;
  } idwnc_row_s;
  logic clk, resetn, nv_init_n, scl_clk, sda_low_m, sda_line, sda_o, sda_oe;
  logic wp, init_busy, standby;
  logic [7:0] wiper_a, wiper_b;
  logic [15:0] nv_word;
  int mismatches = 0;
  int checks_done = 0;
  // Open drain: anyone pulling low wins, otherwise the pull-up
  assign sda_line = (sda_low_m || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  idwnc_master u_idwnc_master (.scl(scl_clk), .sda_low(sda_low_m), .sda_line(sda_line));
  idwnc_top u_idwnc_top (.clk(clk), .resetn(resetn), .nv_init_n(nv_init_n),
    .scl_clk(scl_clk), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_bit0(1'b1), .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1), .wp(wp),
    .wiper_a(wiper_a), .wiper_b(wiper_b), .nv_word(nv_word), .init_busy(init_busy),
    .standby(standby));
  // Address 0101 + straps 101 with write bit low
  localparam logic [7:0] AW = 8'h5a;
  idwnc_row_s rows [13] = '{
    '{1'b0, 8'h11, 8'h12, 8'h12, 8'h80, 16'h8080},
    '{1'b0, 8'h22, 8'h34, 8'h12, 8'h80, 16'h3480},
    '{1'b0, 8'h62, 8'h00, 8'h12, 8'h34, 16'h3480},
    '{1'b0, 8'h53, 8'h00, 8'h12, 8'h34, 16'h3412},
    '{1'b0, 8'h13, 8'h5a, 8'h5a, 8'h5a, 16'h3412},
    '{1'b0, 8'h61, 8'h00, 8'h12, 8'h5a, 16'h3412},
    '{1'b1, 8'h23, 8'h00, 8'h12, 8'h5a, 16'h3412},
    '{1'b1, 8'h53, 8'h00, 8'h12, 8'h5a, 16'h3412},
    '{1'b1, 8'h12, 8'hff, 8'h12, 8'h34, 16'h3412},
    '{1'b0, 8'h7f, 8'h99, 8'h12, 8'h34, 16'h3412},
    '{1'b0, 8'h14, 8'h99, 8'h12, 8'h34, 16'h3412},
    '{1'b0, 8'h21, 8'haa, 8'h12, 8'h34, 16'h34aa},
    '{1'b1, 8'h13, 8'h00, 8'haa, 8'h34, 16'h34aa}
  };
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        mismatches++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task automatic run(input logic [31:0] b, input int n, input logic [3:0] exp_acks);
    logic [3:0] acks;
    begin
      u_idwnc_master.frame(b, n, acks);
      check({12'h000, acks}, {12'h000, exp_acks});
      repeat (8) @(posedge clk);
      #2;
    end
  endtask
  task automatic check_state(input logic [7:0] ea, input logic [7:0] eb, input logic [15:0] env);
    begin
      check({8'h00, wiper_a}, {8'h00, ea});
      check({8'h00, wiper_b}, {8'h00, eb});
      check(nv_word, env);
    end
  endtask
  task automatic do_reset;
    begin
      @(posedge clk);
      #2;
      resetn = 1'b0;
      repeat (16) @(posedge clk);
      #2;
      check({14'h0, init_busy, standby}, 16'h0002);
      resetn = 1'b1;
      repeat (398) @(posedge clk);
      #2;
      check({15'h0, init_busy}, 16'h0001);
      repeat (4) @(posedge clk);
      #2;
      check({15'h0, init_busy}, 16'h0000);
      check({15'h0, standby}, 16'h0001);
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    nv_init_n = 1'b0;
    wp = 1'b0;
    repeat (16) @(posedge clk);
    #2;
    nv_init_n = 1'b1;
    do_reset();
    check_state(8'h80, 8'h80, 16'h8080);
    foreach (rows[i])
    begin
      // Protected value is written to both stores before raising protection
      wp = rows[i].wp;
      repeat (4) @(posedge clk);
      #2;
      run({AW, rows[i].cmd, rows[i].data, 8'h00}, 3, 4'b0111);
      check_state(rows[i].ea, rows[i].eb, rows[i].env);
    end
    wp = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    run({8'h5b, 8'h11, 8'h00, 8'h00}, 3, 4'b0111);
    check_state(8'haa, 8'h34, 16'h34aa);
    run({8'h58, 8'h11, 8'h00, 8'h00}, 3, 4'b0000);
    check_state(8'haa, 8'h34, 16'h34aa);
    run({AW, 8'h11, 8'h00, 8'h00}, 2, 4'b0011);
    check_state(8'haa, 8'h34, 16'h34aa);
    fork
      run({AW, 8'h12, 8'h66, 8'h77}, 4, 4'b1111);
      begin
        #(160*12);
        check({15'h0, standby}, 16'h0000);
      end
    join
    check_state(8'haa, 8'h66, 16'h34aa);
    // Saved store must survive a second reset and seed the wipers again
    do_reset();
    check_state(8'haa, 8'h34, 16'h34aa);
    // Factory load puts both saved bytes back at midscale, live wipers stay
    @(posedge clk);
    #2;
    nv_init_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    nv_init_n = 1'b1;
    check_state(8'haa, 8'h34, 16'h8080);
    finish_test();
  end
  initial
  begin
    #2000000;
    mismatches++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
